/* File: core/urw_top.sv */
// upstream read window check, read pacing and write fragmentation with its fifo
//
// What this block does
// - window 1 base is 64 bits: low word and upper word registers
// - base plus size of window 1 decides smart prefetch eligibility
// - window 1 size is control bits 31:1, two byte granule, up to 4G
// - polarity 0: reads inside window 1 or window 2 are refused smart prefetch
// - polarity 1: only reads inside window 1 or window 2 get smart prefetch
// - window 2 base is 64 bits: low word and upper word registers
// - window 2 size is the full 32-bit size register, up to 4G
// - windows only matter while the smart prefetch mode field is on
// - pacing 000 all data, 001/010/011 1/2/4 left, 1xx 8 left
// - writes split at 32, 64 or 128 byte boundary by bits 31:30
// - write fragment field resets to 10, the 128 byte boundary
//
// The APB slave port is this design's own decision.
`timescale 1ns/10ps

// synchronous fifo with a registered ready flag, valid decoded from the registered level
module urw_fifo
   import urw_pkg::*;
#(
   parameter int WIDTH = 97,
   parameter int DEPTH = 16
)
(
   input  wire logic             clk_in,     // core clock
   input  wire logic             rst_in,     // sync reset, active high
   input  wire logic             ce_in,      // clock enable
   input  wire logic             in_valid_in,  // write side valid
   output logic                  in_ready_out, // write side ready
   input  wire logic [WIDTH-1:0] in_data_in,   // write side data
   output logic                  out_valid_out, // read side valid
   input  wire logic             out_ready_in,  // read side ready
   output logic [WIDTH-1:0]      out_data_out,  // read side data
   output logic [$clog2(DEPTH):0] count_out     // words held
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wptr_reg;
   logic [AW-1:0]    rptr_reg;
   logic [AW:0]      count_reg;
   logic [AW:0]      count_next;
   logic             push;
   logic             pop;

   initial
   begin
      if (DEPTH < 2 || (1 << AW) != DEPTH)
         $error("urw_fifo: depth must be a power of two of at least 2");
   end

   // handshakes and fill level
   assign push          = in_valid_in && in_ready_out;
   assign pop           = out_valid_out && out_ready_in;
   assign count_next    = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   assign out_valid_out = (count_reg != '0);
   assign out_data_out  = mem_reg[rptr_reg];
   assign count_out     = count_reg;

   // storage array
   always_ff @(posedge clk_in)
   begin
      if (ce_in && push)
         mem_reg[wptr_reg] <= in_data_in;
   end

   // pointers, level and registered ready
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         wptr_reg     <= '0;
         rptr_reg     <= '0;
         count_reg    <= '0;
         in_ready_out <= 1'b0;
      end
      else if (ce_in)
      begin
         wptr_reg     <= wptr_reg + AW'(push);
         rptr_reg     <= rptr_reg + AW'(pop);
         count_reg    <= count_next;
         in_ready_out <= (count_next != (AW+1)'(DEPTH));
      end
   end

endmodule : urw_fifo

// top: apb registers, window check, read pacing, write fragmenter
module urw_top
   import urw_pkg::*;
#(
   parameter int NUM_CH     = 4,   // upstream read channels
   parameter int UNIT_W     = 16,  // width of data unit counts
   parameter int FIFO_DEPTH = 16   // write beat fifo depth
)
(
   input  wire logic              clk_in,          // core clock, 20 MHz
   input  wire logic              rst_in,          // sync reset, active high
   input  wire logic              ce_in,           // clock enable
   input  wire logic              psel_in,         // apb select
   input  wire logic              penable_in,      // apb enable
   input  wire logic              pwrite_in,       // apb direction
   input  wire logic [7:0]        paddr_in,        // apb byte address
   input  wire logic [31:0]       pwdata_in,       // apb write data
   output logic                   pready_out,      // apb ready
   output logic [31:0]            prdata_out,      // apb read data
   output logic                   pslverr_out,     // apb error, unmapped
   input  wire logic [3:0]        smart_mode_in,   // smart prefetch mode field
   input  wire logic              chk_valid_in,    // read address to classify
   input  wire logic [63:0]       chk_addr_in,     // pci memory read address
   output logic                   chk_done_out,    // classification valid
   output logic                   chk_smart_ok_out, // smart prefetch allowed
   input  wire logic              rd_valid_in,     // upstream read request
   input  wire logic [$clog2(NUM_CH)-1:0] rd_ch_in, // requesting channel
   input  wire logic [UNIT_W-1:0] rd_units_in,     // data units requested
   output logic                   rd_grant_out,    // request sent, pulse
   output logic [$clog2(NUM_CH)-1:0] rd_grant_ch_out, // granted channel
   input  wire logic              cpl_valid_in,    // completion data arrived
   input  wire logic [$clog2(NUM_CH)-1:0] cpl_ch_in, // completion channel
   input  wire logic [UNIT_W-1:0] cpl_units_in,    // units received
   input  wire logic              wr_valid_in,     // write beat valid
   output logic                   wr_ready_out,    // write beat ready
   input  wire urw_wbeat_s        wr_beat_in,      // write beat
   output logic                   wo_valid_out,    // fragmented beat valid
   input  wire logic              wo_ready_in,     // fragmented beat ready
   output urw_wbeat_s             wo_beat_out,     // beat, last ends fragment
   output logic [$clog2(NUM_CH)-1:0] unused_ch_out // reserved, held zero
);
   localparam int CW = $clog2(NUM_CH);
   localparam int FW = $clog2(FIFO_DEPTH) + 1;

   initial
   begin
      if (NUM_CH < 2 || NUM_CH > 16)
         $error("urw_top: NUM_CH must be 2 to 16");
      if (UNIT_W < 4 || UNIT_W > 32)
         $error("urw_top: UNIT_W must be 4 to 32");
   end

   // register storage
   logic [31:0]    win1_lo_reg;
   logic [31:0]    win1_hi_reg;
   logic [31:0]    win1_ctl_reg;
   logic [31:0]    win2_lo_reg;
   logic [31:0]    win2_hi_reg;
   logic [31:0]    win2_size_reg;
   logic [2:0]     pace_reg;
   logic [1:0]     frag_reg;
   urw_apb_state_e apb_reg;
   urw_apb_state_e apb_next;

   // apb decode
   logic        acc;
   logic        wr_en;
   logic        hit_mapped;
   logic [31:0] rd_mux;
   logic [31:0] status_word;
   logic [FW-1:0] fifo_count;
   logic [NUM_CH-1:0] busy;

   assign acc        = psel_in && penable_in;
   assign wr_en      = acc && pwrite_in && (apb_reg == URW_DONE);
   assign hit_mapped = (paddr_in == URW_WIN1_BASE_LO_OFS) || (paddr_in == URW_WIN1_BASE_HI_OFS)
                    || (paddr_in == URW_WIN1_CTL_OFS)     || (paddr_in == URW_WIN2_BASE_LO_OFS)
                    || (paddr_in == URW_WIN2_BASE_HI_OFS) || (paddr_in == URW_WIN2_SIZE_OFS)
                    || (paddr_in == URW_RW_CTL_OFS)       || (paddr_in == URW_STATUS_OFS);
   assign status_word = (32'(busy) << URW_STAT_BUSY_LSB) | (32'(fifo_count) << URW_STAT_FCNT_LSB);

   // read data selection
   always_comb
   begin
      case (paddr_in)
         URW_WIN1_BASE_LO_OFS: rd_mux = win1_lo_reg;
         URW_WIN1_BASE_HI_OFS: rd_mux = win1_hi_reg;
         URW_WIN1_CTL_OFS:     rd_mux = win1_ctl_reg;
         URW_WIN2_BASE_LO_OFS: rd_mux = win2_lo_reg;
         URW_WIN2_BASE_HI_OFS: rd_mux = win2_hi_reg;
         URW_WIN2_SIZE_OFS:    rd_mux = win2_size_reg;
         URW_RW_CTL_OFS:       rd_mux = {frag_reg, pace_reg, 27'h0000000};
         URW_STATUS_OFS:       rd_mux = status_word;
         default:              rd_mux = 32'h0000_0000;
      endcase
   end

   // apb state: two wait cycles, then pready for one cycle
   always_comb
   begin
      case (apb_reg)
         URW_IDLE: apb_next = acc ? URW_WAIT : URW_IDLE;
         URW_WAIT: apb_next = URW_DONE;
         URW_DONE: apb_next = URW_IDLE;
         default:  apb_next = URW_IDLE;
      endcase
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         apb_reg     <= URW_IDLE;
         pready_out  <= 1'b0;
         prdata_out  <= 32'h0000_0000;
         pslverr_out <= 1'b0;
      end
      else if (ce_in)
      begin
         apb_reg     <= apb_next;
         pready_out  <= (apb_next == URW_DONE);
         prdata_out  <= (apb_next == URW_DONE && !pwrite_in) ? rd_mux : 32'h0000_0000;
         pslverr_out <= (apb_next == URW_DONE) && !hit_mapped;
      end
   end

   // register writes
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         win1_lo_reg   <= URW_REG_RST;
         win1_hi_reg   <= URW_REG_RST;
         win1_ctl_reg  <= URW_REG_RST;
         win2_lo_reg   <= URW_REG_RST;
         win2_hi_reg   <= URW_REG_RST;
         win2_size_reg <= URW_REG_RST;
         pace_reg      <= URW_PACE_RST;
         frag_reg      <= URW_FRAG_RST;
      end
      else if (ce_in && wr_en)
      begin
         case (paddr_in)
            URW_WIN1_BASE_LO_OFS: win1_lo_reg   <= pwdata_in;
            URW_WIN1_BASE_HI_OFS: win1_hi_reg   <= pwdata_in;
            URW_WIN1_CTL_OFS:     win1_ctl_reg  <= pwdata_in;
            URW_WIN2_BASE_LO_OFS: win2_lo_reg   <= pwdata_in;
            URW_WIN2_BASE_HI_OFS: win2_hi_reg   <= pwdata_in;
            URW_WIN2_SIZE_OFS:    win2_size_reg <= pwdata_in;
            URW_RW_CTL_OFS:
            begin
               pace_reg <= pwdata_in[URW_PACE_MSB:URW_PACE_LSB];
               frag_reg <= pwdata_in[URW_FRAG_MSB:URW_FRAG_LSB];
            end
            default: ;
         endcase
      end
   end

   // window bounds
   logic [63:0] win1_base;
   logic [63:0] win2_base;
   logic [31:0] win1_size;
   logic [64:0] win1_end;
   logic [64:0] win2_end;
   logic        in_win1;
   logic        in_win2;
   logic        win_hit;
   logic        smart_ok;
   logic        pol_allow;

   assign win1_base = {win1_hi_reg, win1_lo_reg};
   assign win2_base = {win2_hi_reg, win2_lo_reg};
   assign win1_size = {win1_ctl_reg[31:1], 1'b0};
   assign win1_end  = {1'b0, win1_base} + {33'h0_0000_0000, win1_size};
   assign win2_end  = {1'b0, win2_base} + {33'h0_0000_0000, win2_size_reg};
   assign in_win1   = (chk_addr_in >= win1_base) && ({1'b0, chk_addr_in} < win1_end);
   assign in_win2   = (chk_addr_in >= win2_base) && ({1'b0, chk_addr_in} < win2_end);
   assign win_hit   = in_win1 || in_win2;
   assign pol_allow = win1_ctl_reg[URW_WIN1_POL_BIT] ? win_hit : !win_hit;
   assign smart_ok  = (smart_mode_in != 4'h0) && pol_allow;

   // classification result, one cycle after the address
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         chk_done_out     <= 1'b0;
         chk_smart_ok_out <= 1'b0;
      end
      else if (ce_in)
      begin
         chk_done_out     <= chk_valid_in;
         chk_smart_ok_out <= chk_valid_in && smart_ok;
      end
   end

   // read pacing threshold
   logic [UNIT_W-1:0] thresh;
   logic [UNIT_W-1:0] rem_reg [NUM_CH];
   logic [NUM_CH-1:0] may_send;
   logic              grant;

   assign thresh = pace_reg[2]          ? UNIT_W'(URW_PACE_T8) :
                   (pace_reg == 3'h3)   ? UNIT_W'(URW_PACE_T4) :
                   (pace_reg == 3'h2)   ? UNIT_W'(URW_PACE_T2) :
                   (pace_reg == 3'h1)   ? UNIT_W'(URW_PACE_T1) : '0;

   assign grant = rd_valid_in && may_send[rd_ch_in] && !rd_grant_out;

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++)
      begin : g_ch
         logic [UNIT_W:0] add_v;
         logic [UNIT_W:0] sub_v;
         assign may_send[g] = (rem_reg[g] <= thresh);
         assign busy[g]     = (rem_reg[g] != '0);
         assign add_v = {1'b0, rem_reg[g]}
                      + ((grant && rd_ch_in == CW'(g)) ? {1'b0, rd_units_in} : '0);
         assign sub_v = (cpl_valid_in && cpl_ch_in == CW'(g)) ? {1'b0, cpl_units_in} : '0;

         // outstanding units, saturating at zero and at full scale
         always_ff @(posedge clk_in)
         begin
            if (rst_in)
               rem_reg[g] <= '0;
            else if (ce_in)
               rem_reg[g] <= (add_v <= sub_v) ? '0 :
                             ((add_v - sub_v) > {1'b0, {UNIT_W{1'b1}}}) ? {UNIT_W{1'b1}} :
                             UNIT_W'(add_v - sub_v);
         end
      end
   endgenerate

   // grant pulse
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         rd_grant_out    <= 1'b0;
         rd_grant_ch_out <= '0;
         unused_ch_out   <= '0;
      end
      else if (ce_in)
      begin
         rd_grant_out    <= grant;
         rd_grant_ch_out <= grant ? rd_ch_in : rd_grant_ch_out;
         unused_ch_out   <= '0;
      end
   end

   // write beat fifo
   logic       f_valid;
   logic       f_ready;
   urw_wbeat_s f_beat;
   logic [4:0] frag_mask;
   logic       frag_end;

   urw_fifo #(.WIDTH(URW_WBEAT_W), .DEPTH(FIFO_DEPTH)) u_fifo
   (
      .clk_in        (clk_in),
      .rst_in        (rst_in),
      .ce_in         (ce_in),
      .in_valid_in   (wr_valid_in),
      .in_ready_out  (wr_ready_out),
      .in_data_in    (wr_beat_in),
      .out_valid_out (f_valid),
      .out_ready_in  (f_ready),
      .out_data_out  (f_beat),
      .count_out     (fifo_count)
   );

   assign frag_mask = frag_reg[1] ? URW_MASK_128 : (frag_reg[0] ? URW_MASK_64 : URW_MASK_32);
   assign frag_end  = f_beat.last || ((f_beat.addr[6:2] & frag_mask) == frag_mask);
   assign f_ready   = !wo_valid_out || wo_ready_in;

   // output stage, last marks the end of each fragment
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         wo_valid_out <= 1'b0;
         wo_beat_out  <= '0;
      end
      else if (ce_in && f_ready)
      begin
         wo_valid_out     <= f_valid;
         wo_beat_out.addr <= f_beat.addr;
         wo_beat_out.data <= f_beat.data;
         wo_beat_out.last <= frag_end;
      end
   end

endmodule : urw_top

/* File: core/urw_pkg.sv */
// package: register map, field layout and carriers for the upstream read/write block
package urw_pkg;

   // register byte offsets
   localparam logic [7:0] URW_WIN1_BASE_LO_OFS = 8'h50;
   localparam logic [7:0] URW_WIN1_BASE_HI_OFS = 8'h54;
   localparam logic [7:0] URW_WIN1_CTL_OFS     = 8'h58;
   localparam logic [7:0] URW_WIN2_BASE_LO_OFS = 8'h5C;
   localparam logic [7:0] URW_WIN2_BASE_HI_OFS = 8'h60;
   localparam logic [7:0] URW_WIN2_SIZE_OFS    = 8'h64;
   localparam logic [7:0] URW_RW_CTL_OFS       = 8'h68;
   localparam logic [7:0] URW_STATUS_OFS       = 8'h80;

   // field positions
   localparam int URW_WIN1_POL_BIT  = 0;
   localparam int URW_PACE_LSB      = 27;
   localparam int URW_PACE_MSB      = 29;
   localparam int URW_FRAG_LSB      = 30;
   localparam int URW_FRAG_MSB      = 31;
   localparam int URW_STAT_FCNT_LSB = 0;
   localparam int URW_STAT_BUSY_LSB = 8;

   // reset values
   localparam logic [31:0] URW_REG_RST      = 32'h0000_0000;
   localparam logic [1:0]  URW_FRAG_RST     = 2'h2;
   localparam logic [2:0]  URW_PACE_RST     = 3'h0;

   // pacing thresholds in completion data units
   localparam logic [3:0]  URW_PACE_T1 = 4'h1;
   localparam logic [3:0]  URW_PACE_T2 = 4'h2;
   localparam logic [3:0]  URW_PACE_T4 = 4'h4;
   localparam logic [3:0]  URW_PACE_T8 = 4'h8;

   // fragment boundary masks (byte address bits 6:2 below the boundary)
   localparam logic [4:0]  URW_MASK_32  = 5'h07;
   localparam logic [4:0]  URW_MASK_64  = 5'h0F;
   localparam logic [4:0]  URW_MASK_128 = 5'h1F;

   // apb slave states, gray along idle -> wait -> done
   typedef enum logic [1:0]
   {
      URW_IDLE = 2'h0,
      URW_WAIT = 2'h1,
      URW_DONE = 2'h3
   } urw_apb_state_e;

   // one upstream write beat: dword address, data, end of the write
   typedef struct packed
   {
      logic [63:0] addr;
      logic [31:0] data;
      logic        last;
   } urw_wbeat_s;

   localparam int URW_WBEAT_W = $bits(urw_wbeat_s);

endpackage : urw_pkg

/* File: bench/urw_chk.sv */
// assertion checker for the upstream read window and pacing block
`timescale 1ns/10ps
module urw_chk
   import urw_pkg::*;
#(
   parameter int NUM_CH = 4 // read channels
)
(
   input wire logic                      clk_in,           // clock
   input wire logic                      rst_in,           // reset
   input wire logic                      psel_in,          // apb select
   input wire logic                      penable_in,       // apb enable
   input wire logic                      pready_out,       // apb ready
   input wire logic [31:0]               prdata_out,       // read data
   input wire logic                      pslverr_out,      // apb error
   input wire logic [3:0]                smart_mode_in,    // mode field
   input wire logic                      chk_valid_in,     // check request
   input wire logic                      chk_done_out,     // check done
   input wire logic                      chk_smart_ok_out, // check result
   input wire logic                      rd_valid_in,      // read request
   input wire logic [$clog2(NUM_CH)-1:0] rd_ch_in,         // request channel
   input wire logic                      rd_grant_out,     // read grant
   input wire logic [$clog2(NUM_CH)-1:0] rd_grant_ch_out,  // grant channel
   input wire logic                      wo_valid_out,     // beat valid
   input wire logic                      wo_ready_in,      // beat ready
   input wire urw_wbeat_s                wo_beat_out,      // beat out
   input wire logic [$clog2(NUM_CH)-1:0] unused_ch_out     // reserved
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // apb answer timing and framing
   a_apb_wait: assert property (psel_in && penable_in && !$past(penable_in) |-> ##2 pready_out)
      else $error("apb answer not two cycles after access");
   a_apb_ready: assert property (pready_out |-> psel_in && penable_in ##1 !pready_out)
      else $error("apb ready outside access or too long");
   a_apb_err: assert property (pslverr_out |-> pready_out)
      else $error("apb error without ready");
   a_rdata_idle: assert property (!pready_out |-> prdata_out == 32'h0)
      else $error("read data not zero while idle");
   // check answers next cycle
   a_chk_done: assert property (chk_valid_in |=> chk_done_out && $past(chk_valid_in))
      else $error("check not answered next cycle");
   a_chk_cause: assert property (chk_done_out |-> $past(chk_valid_in))
      else $error("check done without request");
   a_smart_off: assert property (chk_valid_in && smart_mode_in == 4'h0 |=> !chk_smart_ok_out)
      else $error("smart prefetch allowed while mode off");
   a_grant_pulse: assert property (rd_grant_out |-> $past(rd_valid_in) ##1 !rd_grant_out)
      else $error("grant without request or longer than a pulse");
   a_grant_chan: assert property (rd_grant_out |-> rd_grant_ch_out == $past(rd_ch_in))
      else $error("grant channel differs from request");
   a_beat_hold: assert property (wo_valid_out && !wo_ready_in |=> wo_valid_out && $stable(wo_beat_out))
      else $error("beat dropped or changed while stalled");
   a_unused_zero: assert property (unused_ch_out == '0)
      else $error("reserved output not zero");
   c_grant: cover property (rd_grant_out);
   c_smart: cover property (chk_done_out && chk_smart_ok_out);
   c_frag: cover property (wo_valid_out && wo_ready_in && wo_beat_out.last);
   c_err: cover property (pslverr_out);
endmodule : urw_chk

bind urw_top urw_chk #(.NUM_CH(NUM_CH)) i_chk (.clk_in, .rst_in, .psel_in, .penable_in,
   .pready_out, .prdata_out, .pslverr_out, .smart_mode_in, .chk_valid_in, .chk_done_out,
   .chk_smart_ok_out, .rd_valid_in, .rd_ch_in, .rd_grant_out, .rd_grant_ch_out,
   .wo_valid_out, .wo_ready_in, .wo_beat_out, .unused_ch_out);

/* File: bench/urw_sink.sv */
// far-side beat sink: prompt, alternating or stalled acceptance
`timescale 1ns/10ps
module urw_sink
(
   input  wire logic clk_in,   // core clock
   input  wire logic rst_in,   // sync reset
   input  wire logic valid_in, // beat offered
   input  wire logic hold_in,  // stall all
   input  wire logic slow_in,  // every other
   output logic      ready_out // beat ready
);
   logic tog_reg;
   // alternates while beats are offered
   always_ff @(posedge clk_in)
      tog_reg <= rst_in ? 1'b0 : tog_reg ^ valid_in;
   assign ready_out = !hold_in && !(slow_in && tog_reg);
endmodule : urw_sink

/* File: bench/testbench.sv */
// self-checking bench for the upstream read window and pacing block
`timescale 1ns/10ps
`define CK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
   $display("[FAIL] t=%0t got %0h exp %0h", $time, (g), (e)); end end
module testbench
   import urw_pkg::*;
;
   logic        clk_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1, hold = 1'b0, slow = 1'b0;
   logic        psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
   logic        pready_out, pslverr_out, chk_done_out, chk_smart_ok_out, t_chk;
   logic        chk_valid_in = 1'b0, rd_valid_in = 1'b0, cpl_valid_in = 1'b0;
   logic        rd_grant_out, wr_valid_in = 1'b0, wr_ready_out, wo_valid_out, wo_ready_in;
   logic [1:0]  rd_ch_in = 2'h0, rd_grant_ch_out, t_gnt;
   logic [3:0]  smart_mode_in = 4'h0;
   logic [7:0]  paddr_in = 8'h00;
   logic [15:0] rd_units_in = 16'h000C, cpl_units_in = 16'h0000;
   logic [31:0] pwdata_in = 32'h0, prdata_out, st = 32'h0000DBD3, sh [7];
   logic [32:0] t_rd, q_rd [$];
   logic [63:0] chk_addr_in = 64'h0, b1, b2, av [9];
   urw_wbeat_s  wr_beat_in = '0, wo_beat_out, t_wo, q_wo [$];
   logic        q_chk [$];
   logic [1:0]  q_gnt [$];
   int          errors = 0, checks = 0, acc;
   int          thr [8] = '{0, 1, 2, 4, 8, 8, 8, 8};

   urw_top #(.NUM_CH(4), .UNIT_W(16), .FIFO_DEPTH(16)) i_dut
   (
      .clk_in, .rst_in, .ce_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
      .pready_out, .prdata_out, .pslverr_out, .smart_mode_in, .chk_valid_in, .chk_addr_in,
      .chk_done_out, .chk_smart_ok_out, .rd_valid_in, .rd_ch_in, .rd_units_in, .rd_grant_out,
      .rd_grant_ch_out, .cpl_valid_in, .cpl_ch_in(rd_ch_in), .cpl_units_in, .wr_valid_in,
      .wr_ready_out, .wr_beat_in, .wo_valid_out, .wo_ready_in, .wo_beat_out, .unused_ch_out()
   );
   urw_sink i_sink (.clk_in, .rst_in, .valid_in(wo_valid_out), .hold_in(hold), .slow_in(slow),
                    .ready_out(wo_ready_in));

   always #25 clk_in = ~clk_in;

   function automatic logic [31:0] xs();
      st = st ^ (st << 13);
      st = st ^ (st >> 17);
      st = st ^ (st << 5);
      return st;
   endfunction : xs
   function automatic logic inw(logic [63:0] a, logic [63:0] b, logic [31:0] s);
      return {1'b0, a} >= {1'b0, b} && {1'b0, a} < {1'b0, b} + {33'h0, s};
   endfunction : inw
   function automatic logic exp_ok(logic [63:0] a);
      logic hit;
      hit = inw(a, {sh[1], sh[0]}, {sh[2][31:1], 1'b0}) | inw(a, {sh[4], sh[3]}, sh[5]);
      return smart_mode_in != 4'h0 && (sh[2][0] ? hit : !hit);
   endfunction : exp_ok

   // one apb transfer, read result noted
   task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d);
      logic ok;
      ok = a >= 8'h50 && a <= 8'h68 && a[1:0] == 2'h0;
      @(posedge clk_in);
      if (!w)
         q_rd.push_back(ok ? {1'b0, sh[(a - 8'h50) >> 2]} : {a != 8'h80, 32'h0});
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'b1;
      do
         @(posedge clk_in);
      while (pready_out !== 1'b1);
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      if (w && ok)
         sh[(a - 8'h50) >> 2] = (a == 8'h68) ? d & 32'hF800_0000 : d;
   endtask : rw
   task automatic chk(input logic [63:0] a);
      @(posedge clk_in);
      chk_valid_in <= 1'b1;
      chk_addr_in <= a;
      q_chk.push_back(exp_ok(a));
   endtask : chk
   task automatic gnt();
      int n;
      n = 0;
      do
         @(posedge clk_in);
      while (rd_grant_out !== 1'b1 && ++n < 50);
      rd_valid_in <= 1'b0;
   endtask : gnt
   task automatic cpl(input logic [15:0] u);
      @(posedge clk_in);
      cpl_valid_in <= 1'b1;
      cpl_units_in <= u;
      @(posedge clk_in);
      cpl_valid_in <= 1'b0;
   endtask : cpl
   task automatic wb(input logic [63:0] a, input logic l);
      int n;
      logic [4:0] m;
      urw_wbeat_s e;
      n = 0;
      m = sh[6][31] ? URW_MASK_128 : sh[6][30] ? URW_MASK_64 : URW_MASK_32;
      e = '{addr: a, data: xs(), last: l | ((a[6:2] & m) == m)};
      wr_valid_in <= 1'b1;
      wr_beat_in <= '{addr: a, data: e.data, last: l};
      do
         @(posedge clk_in);
      while (wr_ready_out !== 1'b1 && ++n < 8);
      if (wr_ready_out === 1'b1)
      begin
         q_wo.push_back(e);
         acc++;
      end
      else
      begin
         wr_valid_in <= 1'b0;
         @(posedge clk_in);
      end
   endtask : wb
   task automatic drain();
      int n;
      n = 0;
      while (q_wo.size() != 0 && n++ < 400)
         @(posedge clk_in);
   endtask : drain
   task automatic report_and_stop();
      $display("errors=%0d checks=%0d", errors, checks);
      if (errors == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : report_and_stop

   // results compared in the order noted
   always @(posedge clk_in)
   begin
      if (pready_out === 1'b1 && !pwrite_in)
      begin
         t_rd = q_rd.size() ? q_rd.pop_front() : 'x;
         `CK({pslverr_out, prdata_out}, t_rd)
      end
      if (chk_done_out === 1'b1)
      begin
         t_chk = q_chk.size() ? q_chk.pop_front() : 1'bx;
         `CK(chk_smart_ok_out, t_chk)
      end
      if (rd_grant_out === 1'b1)
      begin
         t_gnt = q_gnt.size() ? q_gnt.pop_front() : 2'bxx;
         `CK(rd_grant_ch_out, t_gnt)
      end
      if (wo_valid_out === 1'b1 && wo_ready_in === 1'b1 && ce_in === 1'b1)
      begin
         t_wo = q_wo.size() ? q_wo.pop_front() : 'x;
         `CK(wo_beat_out, t_wo)
      end
   end

   initial
   begin
      foreach (sh[i])
         sh[i] = URW_REG_RST;
      sh[6] = {URW_FRAG_RST, URW_PACE_RST, 27'h0};
      repeat (5) @(posedge clk_in);
      rst_in <= 1'b0;
      // reset values, unmapped and status reads
      for (int i = 0; i < 13; i++)
         rw(1'b0, 8'h50 + 8'(4 * i), 32'h0);
      // fill while stalled at reset boundary
      hold <= 1'b1;
      acc = 0;
      b1 = {xs(), xs() & 32'hFFFF_FFFC};
      for (int i = 0; i < 20; i++)
         wb(b1 + 64'(4 * i), 1'b0);
      wr_valid_in <= 1'b0;
      `CK(acc >= 16 && acc <= 18, 1'b1)
      `CK(wr_ready_out, 1'b0)
      // clock enable low: no beat may slip out unseen
      ce_in <= 1'b0;
      hold <= 1'b0;
      repeat (4) @(posedge clk_in);
      ce_in <= 1'b1;
      drain();
      // every fragment code, slow sink
      slow <= 1'b1;
      for (int f = 0; f < 4; f++)
      begin
         rw(1'b1, 8'h68, {2'(f), 30'h0});
         b1 = {xs(), xs() & 32'hFFFF_FFFC};
         for (int i = 0; i < 40; i++)
            wb(b1 + 64'(4 * i), xs() % 11 == 0);
         wr_valid_in <= 1'b0;
         drain();
      end
      for (int p = 0; p < 4; p++)
      begin
         for (int i = 0; i < 6; i++)
            rw(1'b1, 8'h50 + 8'(4 * i), (i == 2) ? (xs() & 32'hFFFF_FFFE) | p[0] : xs());
         smart_mode_in <= p[1] ? 4'(xs() | 1) : 4'h0;
         b1 = {sh[1], sh[0]};
         b2 = {sh[4], sh[3]};
         av = '{b1 - 1, b1, b1 + {sh[2][31:1], 1'b0} - 1, b1 + {sh[2][31:1], 1'b0},
                b2 - 1, b2, b2 + sh[5] - 1, b2 + sh[5], {xs(), xs()}};
         foreach (av[i])
            chk(av[i]);
         @(posedge clk_in);
         chk_valid_in <= 1'b0;
      end
      for (int c = 0; c < 8; c++)
      begin
         rw(1'b1, 8'h68, {2'h2, 3'(c), 27'h0});
         rd_ch_in <= 2'(xs());
         @(posedge clk_in);
         q_gnt.push_back(rd_ch_in);
         rd_valid_in <= 1'b1;
         gnt();
         @(posedge clk_in);
         rd_valid_in <= 1'b1;
         cpl(16'(11 - thr[c]));
         repeat (4) @(posedge clk_in);
         q_gnt.push_back(rd_ch_in);
         cpl(16'h0001);
         gnt();
         cpl(16'h0020);
      end
      repeat (5) @(posedge clk_in);
      `CK(q_rd.size() + q_chk.size() + q_gnt.size() + q_wo.size(), 0)
      report_and_stop();
   end

   // watchdog for a hung handshake
   initial
   begin
      #2000000;
      errors++;
      report_and_stop();
   end
endmodule : testbench
